/* File: hw/aux_supply_pkg.sv */
package aux_supply_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_VOLATILE_WRITE   = 8'hE5;
    localparam logic [7:0]  CMD_PERSISTENT_WRITE = 8'hE6;
    localparam logic [7:0]  CMD_READ_PREP        = 8'hE7;

    // ------------------------------------------------------------
    // Configuration word layout and values
    // ------------------------------------------------------------
    localparam logic [31:0] CFG_WRITABLE_MASK    = 32'h0001_DFFF;
    localparam logic [31:0] CFG_RESET            = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO            = 32'h0000_0000;

    typedef struct packed {
        logic [14:0] rsv_hi;           // Bits 31:17, read as zero
        logic        aux_on_bit;       // Bit 16
        logic        aux_passthrough_bit; // Bit 15
        logic        aux_ratio_select; // Bit 14, 0 ratio two, 1 ratio three
        logic        rsv13;            // Bit 13, read as zero
        logic [1:0]  aux_drive_select; // Bits 12:11, quarters of strength
        logic [2:0]  aux_clock_divide; // Bits 10:8, divide by 2**code
        logic        aux_closed_loop_bit; // Bit 7
        logic [6:0]  aux_level_code;   // Bits 6:0, 00h min to 7Fh max
    } aux_cfg_t;

    // ------------------------------------------------------------
    // Serial framing and timing
    // ------------------------------------------------------------
    localparam logic [2:0]  BIT_FIRST            = 3'h0;
    localparam logic [2:0]  BIT_LAST             = 3'h7;
    localparam logic [2:0]  DATA_BYTE_LAST       = 3'h3;
    localparam logic [2:0]  BYTE_FIRST           = 3'h0;
    localparam logic [1:0]  BOOT_SETTLE          = 2'h3;
    localparam logic [1:0]  BOOT_ZERO            = 2'h0;
    localparam logic [7:0]  BYTE_ZERO            = 8'h00;
    localparam logic [6:0]  DIV_ONE              = 7'h01;
    localparam logic [6:0]  DIV_ZERO             = 7'h00;

    // ------------------------------------------------------------
    // Synchronised pin indices
    // ------------------------------------------------------------
    localparam int          PIN_COUNT            = 4;
    localparam int          PIN_SCK              = 0;
    localparam int          PIN_CS_N             = 1;
    localparam int          PIN_MOSI             = 2;
    localparam int          PIN_STRAP            = 3;
    localparam logic [3:0]  PIN_RESET            = 4'h2;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_CMD     = 5'b00010,
        ST_DATA    = 5'b00100,
        ST_READOUT = 5'b01000,
        ST_IGNORE  = 5'b10000
    } spi_state_t;

endpackage

/* File: hw/aux_supply_config_register.sv */
`timescale 1ns/10ps
module aux_supply_config_register
    import aux_supply_pkg::*;
#(
    parameter logic [7:0] WRITE_ENABLE_CMD     = 8'h06,
    parameter logic [7:0] REGISTER_READOUT_CMD = 8'h05
) (
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic       por_n_i,
    input  wire logic       spi_sck_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_mosi_i,
    input  wire logic       supply_range_strap_i,
    output logic            spi_miso_o,
    output logic            spi_miso_oe_n_o,
    output logic            aux_on_bit_o,
    output logic            aux_passthrough_bit_o,
    output logic            aux_ratio_select_o,
    output logic [1:0]      aux_drive_select_o,
    output logic [2:0]      aux_clock_divide_o,
    output logic            aux_closed_loop_bit_o,
    output logic [6:0]      aux_level_code_o,
    output logic            aux_conv_tick_o,
    output logic            fixed_high_supply_mode_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0]   pin_raw, sync1, sync2, sync3, filt, next_filt;
    assign pin_raw = {supply_range_strap_i, spi_mosi_i, spi_cs_n_i, spi_sck_i};
    // A level counts only once stages two and three agree
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        always_comb next_filt[g] = (sync2[g] == sync3[g]) ? sync3[g] : filt[g];
    end
    // Three-stage capture of the asynchronous pins
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            sync1 <= PIN_RESET;
            sync2 <= PIN_RESET;
            sync3 <= PIN_RESET;
            filt  <= PIN_RESET;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= next_filt;
        end
    end

    logic        sck_rise, sck_fall, cs_active, mosi_bit;
    assign sck_rise  = next_filt[PIN_SCK] & ~filt[PIN_SCK];
    assign sck_fall  = ~next_filt[PIN_SCK] & filt[PIN_SCK];
    assign cs_active = ~filt[PIN_CS_N];
    assign mosi_bit  = next_filt[PIN_MOSI];

    // ------------------------------------------------------------
    // Serial command engine
    // ------------------------------------------------------------
    spi_state_t  state, next_state;
    logic [2:0]  bit_cnt, next_bit_cnt, byte_cnt, next_byte_cnt;
    logic [7:0]  shift_in, next_shift_in, cmd, next_cmd, rx_byte;
    logic [31:0] word, next_word, read_buf, next_read_buf, out_sr, next_out_sr, write_word;
    logic        wel, next_wel, read_ready, next_read_ready;
    logic        miso, next_miso, miso_oe_n, next_miso_oe_n;
    logic        commit_vol, commit_pers, prep_read, byte_done;
    aux_cfg_t    cfg;
    assign rx_byte    = {shift_in[6:0], mosi_bit};
    assign write_word = {word[23:0], rx_byte};
    assign byte_done  = sck_rise && (bit_cnt == BIT_LAST);

    // Mode 0: capture on rising clock, launch on falling clock
    always_comb begin
        next_state      = state;
        next_bit_cnt    = bit_cnt;
        next_byte_cnt   = byte_cnt;
        next_shift_in   = shift_in;
        next_cmd        = cmd;
        next_word       = word;
        next_read_buf   = read_buf;
        next_out_sr     = out_sr;
        next_wel        = wel;
        next_read_ready = read_ready;
        next_miso       = miso;
        commit_vol      = 1'b0;
        commit_pers     = 1'b0;
        prep_read       = 1'b0;
        if (sck_rise) begin
            next_shift_in = rx_byte;
            next_bit_cnt  = bit_cnt + 3'h1;
        end
        if (!cs_active) begin
            next_state    = ST_IDLE;
            next_bit_cnt  = BIT_FIRST;
            next_byte_cnt = BYTE_FIRST;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state   = ST_CMD;
                    next_bit_cnt = BIT_FIRST;
                end
                ST_CMD: begin
                    if (byte_done) begin
                        next_cmd   = rx_byte;
                        next_state = ST_IGNORE;
                        if (rx_byte == CMD_VOLATILE_WRITE || rx_byte == CMD_PERSISTENT_WRITE) begin
                            next_state = ST_DATA;
                        end else if (rx_byte == CMD_READ_PREP) begin
                            prep_read       = 1'b1;
                            next_read_buf   = cfg;
                            next_read_ready = 1'b1;
                        end else if (rx_byte == WRITE_ENABLE_CMD) begin
                            next_wel = 1'b1;
                        end else if (rx_byte == REGISTER_READOUT_CMD && read_ready) begin
                            next_out_sr = read_buf;
                            next_state  = ST_READOUT;
                        end
                    end
                end
                ST_DATA: begin
                    if (byte_done) begin
                        next_word     = write_word;
                        next_byte_cnt = byte_cnt + 3'h1;
                        if (byte_cnt == DATA_BYTE_LAST) begin
                            next_state  = ST_IGNORE;
                            commit_vol  = (cmd == CMD_VOLATILE_WRITE);
                            commit_pers = (cmd == CMD_PERSISTENT_WRITE);
                            if (cmd == CMD_PERSISTENT_WRITE) begin
                                next_wel = 1'b0; // Enable is spent by one store
                            end
                        end
                    end
                end
                ST_READOUT: begin
                    if (sck_fall) begin
                        next_miso   = out_sr[31];
                        next_out_sr = {out_sr[30:0], 1'b0};
                    end
                end
                ST_IGNORE: next_state = ST_IGNORE;
                default:   next_state = ST_IDLE;
            endcase
        end
        next_miso_oe_n = (next_state != ST_READOUT);
    end
    // Serial engine state, cleared by the functional reset
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            state      <= ST_IDLE;
            bit_cnt    <= BIT_FIRST;
            byte_cnt   <= BYTE_FIRST;
            shift_in   <= BYTE_ZERO;
            cmd        <= BYTE_ZERO;
            word       <= WORD_ZERO;
            read_buf   <= WORD_ZERO;
            out_sr     <= WORD_ZERO;
            wel        <= 1'b0;
            read_ready <= 1'b0;
            miso       <= 1'b0;
            miso_oe_n  <= 1'b1;
        end else begin
            state      <= next_state;
            bit_cnt    <= next_bit_cnt;
            byte_cnt   <= next_byte_cnt;
            shift_in   <= next_shift_in;
            cmd        <= next_cmd;
            word       <= next_word;
            read_buf   <= next_read_buf;
            out_sr     <= next_out_sr;
            wel        <= next_wel;
            read_ready <= next_read_ready;
            miso       <= next_miso;
            miso_oe_n  <= next_miso_oe_n;
        end
    end

    // ------------------------------------------------------------
    // Configuration, persistent copy, strap and clock divider
    // ------------------------------------------------------------
    aux_cfg_t    next_cfg;
    logic [31:0] persist, next_persist;
    logic [1:0]  boot_cnt, next_boot_cnt;
    logic        boot_done, next_boot_done, boot_load, fixed_high_supply_mode, next_fhs, tick, next_tick;
    logic [6:0]  div_cnt, next_div_cnt, div_mask;
    // Strap is caught only once the synchroniser has filled; code 7 wraps the mask to all ones
    assign boot_load = !boot_done && (boot_cnt == BOOT_SETTLE);
    assign div_mask  = (DIV_ONE << cfg.aux_clock_divide) - DIV_ONE;
    always_comb begin
        next_cfg       = cfg;
        next_persist   = persist;
        next_boot_cnt  = boot_cnt;
        next_boot_done = boot_done;
        next_fhs       = fixed_high_supply_mode;
        next_div_cnt   = div_cnt + DIV_ONE;
        next_tick      = cfg.aux_on_bit && ((div_cnt & div_mask) == DIV_ZERO);
        if (!boot_done && boot_cnt != BOOT_SETTLE) begin
            next_boot_cnt = boot_cnt + 2'h1;
        end
        if (boot_load) begin
            next_cfg       = persist;
            next_fhs       = ~next_filt[PIN_STRAP];
            next_boot_done = 1'b1;
        end else if (commit_vol) begin
            next_cfg = write_word & CFG_WRITABLE_MASK;
        end
        if (commit_pers && wel) begin
            next_persist = write_word & CFG_WRITABLE_MASK;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            cfg       <= CFG_RESET;
            boot_cnt  <= BOOT_ZERO;
            boot_done <= 1'b0;
            fixed_high_supply_mode       <= 1'b0;
            div_cnt   <= DIV_ZERO;
            tick      <= 1'b0;
        end else begin
            cfg       <= next_cfg;
            boot_cnt  <= next_boot_cnt;
            boot_done <= next_boot_done;
            fixed_high_supply_mode       <= next_fhs;
            div_cnt   <= next_div_cnt;
            tick      <= next_tick;
        end
    end

    // Persistent copy survives the functional reset, cleared only at power-on
    always_ff @(posedge clock_i) begin
        if (!por_n_i) begin
            persist <= CFG_RESET;
        end else begin
            persist <= next_persist;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign spi_miso_o               = miso;
    assign spi_miso_oe_n_o          = miso_oe_n;
    assign aux_on_bit_o             = cfg.aux_on_bit;
    assign aux_passthrough_bit_o    = cfg.aux_passthrough_bit;
    assign aux_ratio_select_o       = cfg.aux_ratio_select;
    assign aux_drive_select_o       = cfg.aux_drive_select;
    assign aux_clock_divide_o       = cfg.aux_clock_divide;
    assign aux_closed_loop_bit_o    = cfg.aux_closed_loop_bit;
    assign aux_level_code_o         = cfg.aux_level_code;
    assign aux_conv_tick_o          = tick;
    assign fixed_high_supply_mode_o = fixed_high_supply_mode;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_RSV_ZERO: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (cfg.rsv_hi == 15'h0000) && (cfg.rsv13 == 1'b0) && ((read_buf & ~CFG_WRITABLE_MASK) == WORD_ZERO))
        else $error("reserved configuration bits not zero");
    AST_VOL_WRITE: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (commit_vol && !boot_load) |=> ({aux_on_bit_o, aux_passthrough_bit_o, aux_ratio_select_o,
            aux_drive_select_o, aux_clock_divide_o, aux_closed_loop_bit_o, aux_level_code_o}
            == {$past(write_word[16:14]), $past(write_word[12:0])}))
        else $error("volatile write did not reach outputs");
    AST_PERS_NEEDS_ENABLE: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (commit_pers && !wel) |=> $stable(persist)) else $error("persistent copy changed without write enable");
    AST_PERS_STORE: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (commit_pers && wel) |=> (persist == ($past(write_word) & CFG_WRITABLE_MASK)) && !wel)
        else $error("persistent store or enable clear wrong");
    AST_BOOT_RELOAD: assert property (@(posedge clock_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> ##3 (boot_load ##1 (cfg == $past(persist)))) else $error("no reload after reset");
    AST_STRAP_MODE: assert property (@(posedge clock_i) disable iff (!nrst_i)
        boot_load |=> (fixed_high_supply_mode_o == ~$past(next_filt[PIN_STRAP])) ##1 $stable(fixed_high_supply_mode_o))
        else $error("supply mode strap not honoured");
    AST_DIV_FULL: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ($past(cfg.aux_clock_divide) == 3'h0 && $past(cfg.aux_on_bit)) |-> aux_conv_tick_o)
        else $error("undivided converter clock missed a tick");
    AST_DIV_128: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ($past(cfg.aux_clock_divide) == 3'h7 && aux_conv_tick_o) |-> ($past(div_cnt) == DIV_ZERO))
        else $error("divide by 128 ticked off phase");
    AST_READ_PREP: assert property (@(posedge clock_i) disable iff (!nrst_i)
        prep_read |=> (read_buf == $past(cfg)) && read_ready) else $error("read preparation did not snapshot");
    AST_READOUT_MSB: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state == ST_READOUT && cs_active && sck_fall) |=> (spi_miso_o == $past(out_sr[31])) && !spi_miso_oe_n_o)
        else $error("readout bit not driven");

endmodule

/* File: tb/spi_host_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Behavioural SPI host, mode 0, MSB first
// ------------------------------------------------------------
module spi_host_model #(
    parameter int HALF = 16
) (
    input  wire logic clock_i,
    input  wire logic miso_i,
    input  wire logic miso_oe_n_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      mosi_o
);
    // Idle: clock parked low, select high
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // One command per select frame; caller orders enable and prep frames
    task automatic frame(input logic [7:0] cmd, input int nbytes, input logic [31:0] wdata,
                         output logic [31:0] rdata, output logic drove);
        logic [39:0] sh;
        int          i;
        sh    = {cmd, wdata};
        rdata = 32'h0000_0000;
        drove = 1'b0;
        @(negedge clock_i);
        cs_n_o <= 1'b0;
        for (i = 0; i < 8 + 8 * nbytes; i++) begin
            mosi_o <= sh[39 - i];
            repeat (HALF) @(negedge clock_i);
            sck_o <= 1'b1;
            // A released line reads as the inverse of its last level
            rdata = {rdata[30:0], miso_oe_n_i ? ~miso_i : miso_i};
            drove = drove | ~miso_oe_n_i;
            repeat (HALF) @(negedge clock_i);
            sck_o <= 1'b0;
        end
        repeat (HALF) @(negedge clock_i);
        cs_n_o <= 1'b1;
        // Released line shows the inverse so a stale bit never looks valid
        mosi_o <= ~mosi_o;
        repeat (8) @(negedge clock_i);
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top
    import aux_supply_pkg::*;
;
    localparam logic [7:0] WEN_CMD = 8'h06;
    localparam logic [7:0] RDO_CMD = 8'h05;

    logic        clock_i;
    logic        nrst_i;
    logic        por_n_i;
    logic        strap;
    logic        sck;
    logic        cs_n;
    logic        mosi;
    logic        miso;
    logic        miso_oe_n;
    logic        on_bit;
    logic        pass_bit;
    logic        ratio;
    logic        loop_bit;
    logic        tick;
    logic        fixed_high_supply_mode;
    logic [1:0]  drv;
    logic [2:0]  div;
    logic [6:0]  lvl;
    logic [31:0] rd;
    logic        drove;
    int          num_errors;
    int          total_checks;
    int          i;
    int          n;
    logic [31:0] w;
    logic [31:0] words [4] = '{32'hFFFF_FFFF, 32'h5555_AAAA, 32'hAAAA_5555, 32'h0000_0000};

    // ------------------------------------------------------------
    // Design, host and clock
    // ------------------------------------------------------------
    aux_supply_config_register #(
        .WRITE_ENABLE_CMD     (WEN_CMD),
        .REGISTER_READOUT_CMD (RDO_CMD)
    ) u_dut (
        .clock_i                  (clock_i),
        .nrst_i                   (nrst_i),
        .por_n_i                  (por_n_i),
        .spi_sck_i                (sck),
        .spi_cs_n_i               (cs_n),
        .spi_mosi_i               (mosi),
        .supply_range_strap_i     (strap),
        .spi_miso_o               (miso),
        .spi_miso_oe_n_o          (miso_oe_n),
        .aux_on_bit_o             (on_bit),
        .aux_passthrough_bit_o    (pass_bit),
        .aux_ratio_select_o       (ratio),
        .aux_drive_select_o       (drv),
        .aux_clock_divide_o       (div),
        .aux_closed_loop_bit_o    (loop_bit),
        .aux_level_code_o         (lvl),
        .aux_conv_tick_o          (tick),
        .fixed_high_supply_mode_o (fixed_high_supply_mode)
    );

    spi_host_model u_host (
        .clock_i     (clock_i),
        .miso_i      (miso),
        .miso_oe_n_i (miso_oe_n),
        .sck_o       (sck),
        .cs_n_o      (cs_n),
        .mosi_o      (mosi)
    );

    // 200 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] cfg_seen();
        return {15'h0000, on_bit, pass_bit, ratio, 1'b0, drv, div, loop_bit, lvl};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Reset clears live word but keeps the stored copy; boot reload needs a few edges
    task automatic do_reset(input logic s);
        @(negedge clock_i);
        strap  = s;
        nrst_i = 1'b0;
        repeat (4) @(negedge clock_i);
        check("cfg_in_reset", cfg_seen(), 32'h0000_0000);
        check("oe_n_in_reset", {31'h0, miso_oe_n}, 32'h0000_0001);
        nrst_i = 1'b1;
        repeat (12) @(negedge clock_i);
    endtask

    task automatic readback();
        u_host.frame(CMD_READ_PREP, 0, 32'h0000_0000, rd, drove);
        u_host.frame(RDO_CMD, 4, 32'h0000_0000, rd, drove);
    endtask

    task automatic results();
        $display("Checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog at 80k cycles, well above the expected run of about 30k cycles
    initial begin
        #400000;
        num_errors++;
        results();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        num_errors   = 0;
        total_checks = 0;
        nrst_i       = 1'b0;
        por_n_i      = 1'b0;
        strap        = 1'b0;
        repeat (2) @(negedge clock_i);
        por_n_i = 1'b1;
        do_reset(1'b0);
        check("fhs_low_strap", {31'h0, fixed_high_supply_mode}, 32'h0000_0001);
        check("cfg_defaults", cfg_seen(), 32'h0000_0000);
        strap = 1'b1;
        u_host.frame(RDO_CMD, 4, 32'h0000_0000, rd, drove);
        check("fhs_latched", {31'h0, fixed_high_supply_mode}, 32'h0000_0001);
        check("readout_no_prep", {31'h0, drove}, 32'h0000_0000);
        do_reset(1'b1);
        check("fhs_high_strap", {31'h0, fixed_high_supply_mode}, 32'h0000_0000);
        // Volatile writes with no enable, then readback of each
        for (i = 0; i < 4; i++) begin
            u_host.frame(CMD_VOLATILE_WRITE, 4, words[i], rd, drove);
            check("cfg_fields", cfg_seen(), words[i] & 32'h0001_DFFF);
            readback();
            check("readback", rd, words[i] & 32'h0001_DFFF);
            check("oe_n_after", {31'h0, miso_oe_n}, 32'h0000_0001);
        end
        // Every drive and divider code, converter on
        for (i = 0; i < 8; i++) begin
            w = 32'h0001_0000 | (32'(i % 4) << 11) | (32'(i) << 8);
            u_host.frame(CMD_VOLATILE_WRITE, 4, w, rd, drove);
            check("drive_div", cfg_seen(), w);
            n = 0;
            repeat (256) begin
                @(negedge clock_i);
                n += int'(tick);
            end
            check("tick_count", 32'(n), 32'(256 >> i));
        end
        u_host.frame(CMD_VOLATILE_WRITE, 4, 32'h0000_0000, rd, drove);
        n = 0;
        repeat (64) begin
            @(negedge clock_i);
            n += int'(tick);
        end
        check("tick_off", 32'(n), 32'h0000_0000);
        // Short frame must not write
        u_host.frame(CMD_VOLATILE_WRITE, 2, 32'hFFFF_FFFF, rd, drove);
        check("short_frame", cfg_seen(), 32'h0000_0000);
        // Stored copy: refused without enable, reloaded at reset with it
        u_host.frame(CMD_PERSISTENT_WRITE, 4, 32'hFFFF_7A3C, rd, drove);
        check("persist_live", cfg_seen(), 32'h0000_0000);
        do_reset(1'b1);
        check("persist_no_wen", cfg_seen(), 32'h0000_0000);
        u_host.frame(WEN_CMD, 0, 32'h0000_0000, rd, drove);
        u_host.frame(CMD_PERSISTENT_WRITE, 4, 32'hFFFF_7A3C, rd, drove);
        check("persist_live2", cfg_seen(), 32'h0000_0000);
        do_reset(1'b1);
        check("persist_reload", cfg_seen(), 32'hFFFF_7A3C & 32'h0001_DFFF);
        results();
    end
endmodule
